// ==== core/hb_dead_time.sv ====
// one half bridge: turns a drive request into gate enables
// assumes the request comes from logic on the same clock
`timescale 1ns/10ps
module hb_dead_time #(
    parameter int DEAD_CYCLES = hbridge_pkg::DEAD_CYCLES_DEF
) (
    input  wire logic                  clock,    // 50 MHz clock
    input  wire logic                  sys_rst,  // sync reset, high
    input  wire hbridge_pkg::hb_drive_t req,     // wanted drive
    output hbridge_pkg::hb_gate_t      gate      // gate enables
);
    import hbridge_pkg::*;

    localparam int CW = $clog2(DEAD_CYCLES + 1);
    localparam logic [CW-1:0] DEAD_LOAD = CW'(DEAD_CYCLES);

    hb_drive_t     appliedReg, appliedNext;
    logic [CW-1:0] deadReg, deadNext;
    hb_gate_t      gateReg, gateNext;

    // ==========================================================
    // dead time sequencing
    // off before swap
    // any change passes through off, so hi and lo never overlap
    always_comb begin
        appliedNext = appliedReg;
        deadNext    = deadReg;
        if (req != appliedReg) begin
            if (req == HB_OFF || appliedReg != HB_OFF) begin
                appliedNext = HB_OFF;
                deadNext    = DEAD_LOAD;
            end else if (deadReg != '0) begin
                deadNext = deadReg - 1'b1;
            end else begin
                appliedNext = req;
            end
        end
        gateNext.hiOn = (appliedNext == HB_HIGH);
        gateNext.loOn = (appliedNext == HB_LOW);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            appliedReg <= HB_OFF;
            deadReg    <= '0;
            gateReg    <= GATE_OFF;
        end else begin
            appliedReg <= appliedNext;
            deadReg    <= deadNext;
            gateReg    <= gateNext;
        end
    end

    assign gate = gateReg;

    // ==========================================================
    // checks
    no_overlap_a: assert property (@(posedge clock) disable iff (sys_rst)
        !(gate.hiOn && gate.loOn))
        else $error("both switches of a half bridge on");
    swap_gap_a: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(gate.hiOn) |-> !gate.loOn [*2])
        else $error("low switch on without dead time");
    swap_gap_lo_a: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(gate.loOn) |-> !gate.hiOn [*2])
        else $error("high switch on without dead time");

endmodule

// ==== core/hbridge_mode_and_fault_control.sv ====
// h-bridge mode decode, dead time and protection shutdown control
// assumes protection flags and direction pins are asynchronous levels
//
// Contract
// - both direction inputs high gives short brake regardless of pwm
// - one direction high drives while pwm high, brakes while pwm low
// - both direction inputs low puts both outputs off
// - fault pin driven low during normal operation
// - fault pin released while any shutdown is active
// - host clears a shutdown by driving both direction inputs low
// - undervoltage flag turns outputs off until it clears
// - thermal flag latches outputs off until recovery or release
// - thermal or overcurrent shutdown recovers after the stop interval
// - grounded oscillator pin disables thermal auto recovery
// - open oscillator pin disables overcurrent auto recovery
// - any of four switch overcurrents trips all outputs off
// - overcurrent flag filtered for the selected detection time
// - dead time inserted whenever a half bridge swaps conduction
// - direct mode changes handled safely by internal dead time
`timescale 1ns/10ps
module hbridge_mode_and_fault_control #(
    parameter int DEAD_CYCLES = hbridge_pkg::DEAD_CYCLES_DEF
) (
    input  wire logic                     clock,      // 50 MHz clock
    input  wire logic                     sys_rst,    // sync reset
    input  wire hbridge_pkg::drive_cmd_t  driveCmd,   // dir and pwm pins
    input  wire hbridge_pkg::prot_flags_t protFlags,  // comparator flags
    input  wire logic                     recoveryOsc, // osc pin
    input  wire logic                     oscGrounded, // osc tied low
    input  wire logic                     oscOpen,     // osc left open
    input  wire logic [1:0]               overcurrentTimeSelect, // time
    output hbridge_pkg::hb_gate_t         bridgeOutA, // half bridge a
    output hbridge_pkg::hb_gate_t         bridgeOutB, // half bridge b
    input  wire logic                     faultIn,    // fault pin level
    output logic                          faultOut,   // fault pin data
    output logic                          faultOe     // fault pin enable
);
    import hbridge_pkg::*;

    typedef struct packed {
        drive_cmd_t  cmd;
        prot_flags_t flags;
        logic        osc;
        logic        oscGnd;
        logic        oscOpn;
    } pin_sample_t;

    pin_sample_t  pinNow, stage1Reg, stage2Reg;
    logic         oscPrevReg;
    logic         oscRise;
    logic         dirA, dirB, pwm, uv, ov, hot, stopCmd;
    logic [OC_CNT_W-1:0] ocLimit;
    logic [NUM_SWITCHES-1:0] ocHit;
    logic         ocTrip, tripNow, autoOk, driveOk;
    guard_state_t stateReg, stateNext;
    logic         causeHotReg, causeHotNext;
    logic         causeOcReg, causeOcNext;
    logic [EDGE_CNT_W-1:0] edgeReg, edgeNext;
    hb_drive_t    reqA, reqB;
    logic         faultOeReg, faultOeNext;

    localparam logic [EDGE_CNT_W-1:0] EDGE_LAST =
        EDGE_CNT_W'(STOP_EDGES - 1);

    // ==========================================================
    // pin synchronisers
    // two stages before use; only stage 2 feeds the logic
    always_comb begin
        pinNow.cmd    = driveCmd;
        pinNow.flags  = protFlags;
        pinNow.osc    = recoveryOsc;
        pinNow.oscGnd = oscGrounded;
        pinNow.oscOpn = oscOpen;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stage1Reg  <= '0;
            stage2Reg  <= '0;
            oscPrevReg <= 1'b0;
        end else begin
            stage1Reg  <= pinNow;
            stage2Reg  <= stage1Reg;
            oscPrevReg <= stage2Reg.osc;
        end
    end

    // synchronised views
    assign dirA    = stage2Reg.cmd.dirInA;
    assign dirB    = stage2Reg.cmd.dirInB;
    assign pwm     = stage2Reg.cmd.pwmIn;
    assign uv      = stage2Reg.flags.undervoltageLockout;
    assign ov      = stage2Reg.flags.overvoltageShutdown;
    assign hot     = stage2Reg.flags.thermalShutdown;
    assign stopCmd = !dirA && !dirB;
    assign oscRise = stage2Reg.osc && !oscPrevReg;

    // ==========================================================
    // overcurrent filters
    // detection time select
    // unused code falls back to the longest time, the safer miss
    always_comb begin
        unique case (overcurrentTimeSelect)
            OC_SEL_FAST: ocLimit = OC_CNT_W'(OC_CYC_FAST);
            OC_SEL_MID:  ocLimit = OC_CNT_W'(OC_CYC_MID);
            default:     ocLimit = OC_CNT_W'(OC_CYC_SLOW);
        endcase
    end

    for (genvar i = 0; i < NUM_SWITCHES; i++) begin : g_oc
        logic [OC_CNT_W-1:0] cntReg, cntNext;
        always_comb begin
            cntNext = '0;
            if (stage2Reg.flags.overcurrentShutdown[i]) begin
                cntNext = (cntReg >= ocLimit) ? cntReg : cntReg + 1'b1;
            end
        end
        always_ff @(posedge clock) begin
            if (sys_rst) begin
                cntReg <= '0;
            end else begin
                cntReg <= cntNext;
            end
        end
        assign ocHit[i] = (cntReg >= ocLimit);
    end

    assign ocTrip  = |ocHit;
    assign tripNow = hot || ocTrip;
    assign autoOk  = !(causeHotReg && stage2Reg.oscGnd)
                  && !(causeOcReg && stage2Reg.oscOpn);

    // ==========================================================
    // shutdown state machine
    // a new trip wins over release in the same cycle
    always_comb begin
        stateNext    = stateReg;
        causeHotNext = causeHotReg;
        causeOcNext  = causeOcReg;
        edgeNext     = edgeReg;
        unique case (stateReg)
            ST_RUN: begin
                if (tripNow) begin
                    stateNext    = ST_TRIP;
                    causeHotNext = hot;
                    causeOcNext  = ocTrip;
                    edgeNext     = '0;
                end
            end
            ST_TRIP: begin
                if (tripNow) begin
                    causeHotNext = causeHotReg || hot;
                    causeOcNext  = causeOcReg || ocTrip;
                    edgeNext     = '0;
                end else if (stopCmd) begin
                    stateNext    = ST_RUN;
                    causeHotNext = 1'b0;
                    causeOcNext  = 1'b0;
                end else if (oscRise) begin
                    if (edgeReg == EDGE_LAST) begin
                        if (autoOk) begin
                            stateNext    = ST_RUN;
                            causeHotNext = 1'b0;
                            causeOcNext  = 1'b0;
                        end
                    end else begin
                        edgeNext = edgeReg + 1'b1;
                    end
                end
            end
            default: begin
                stateNext = ST_TRIP;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stateReg    <= ST_RUN;
            causeHotReg <= 1'b0;
            causeOcReg  <= 1'b0;
            edgeReg     <= '0;
        end else begin
            stateReg    <= stateNext;
            causeHotReg <= causeHotNext;
            causeOcReg  <= causeOcNext;
            edgeReg     <= edgeNext;
        end
    end

    // ==========================================================
    // mode decode
    // undervoltage off
    assign driveOk = (stateReg == ST_RUN) && !uv && !ov;

    // pwm on the direction pins works too, with pwm held high
    always_comb begin
        reqA = HB_OFF;
        reqB = HB_OFF;
        if (driveOk && !stopCmd) begin
            if (dirA && dirB) begin
                reqA = HB_LOW;
                reqB = HB_LOW;
            end else if (pwm) begin
                reqA = dirA ? HB_HIGH : HB_LOW;
                reqB = dirA ? HB_LOW : HB_HIGH;
            end else begin
                reqA = HB_LOW;
                reqB = HB_LOW;
            end
        end
    end

    hb_dead_time #(.DEAD_CYCLES(DEAD_CYCLES)) u_leg_a (
        .clock   (clock),
        .sys_rst (sys_rst),
        .req     (reqA),
        .gate    (bridgeOutA)
    );

    hb_dead_time #(.DEAD_CYCLES(DEAD_CYCLES)) u_leg_b (
        .clock   (clock),
        .sys_rst (sys_rst),
        .req     (reqB),
        .gate    (bridgeOutB)
    );

    // ==========================================================
    // fault indicator, open drain
    // driven low when normal
    always_comb begin
        faultOeNext = driveOk;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            faultOeReg <= 1'b0;
        end else begin
            faultOeReg <= faultOeNext;
        end
    end

    assign faultOe  = faultOeReg;
    assign faultOut = 1'b0;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // longest run of any overcurrent flag; kept apart from the per switch
    // counters so the filter check does not judge them by themselves
    logic [OC_CNT_W-1:0] ocRunReg, ocRunNext;

    always_comb begin
        ocRunNext = '0;
        if (stage2Reg.flags.overcurrentShutdown != 4'h0) begin
            ocRunNext = (ocRunReg == '1) ? ocRunReg : ocRunReg + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ocRunReg <= '0;
        end else begin
            ocRunReg <= ocRunNext;
        end
    end

    brake_decode_a: assert property (driveOk && dirA && dirB
        |-> reqA == HB_LOW && reqB == HB_LOW)
        else $error("short brake not requested");
    drive_decode_a: assert property (driveOk && dirA && !dirB
        && pwm |-> reqA == HB_HIGH && reqB == HB_LOW)
        else $error("drive phase wrong");
    stop_outputs_a: assert property (stopCmd [*2] |=>
        bridgeOutA == GATE_OFF && bridgeOutB == GATE_OFF)
        else $error("outputs on in stop mode");
    fault_low_a: assert property (stateReg == ST_RUN && !uv && !ov
        |=> faultOe)
        else $error("fault pin not driven low");
    fault_release_a: assert property (uv || ov || stateReg == ST_TRIP
        |=> !faultOe)
        else $error("fault pin driven during shutdown");
    host_release_a: assert property (stateReg == ST_TRIP && stopCmd
        && !tripNow |=> stateReg == ST_RUN)
        else $error("host release ignored");
    supply_off_a: assert property ((uv || ov) [*2] |=>
        bridgeOutA == GATE_OFF && bridgeOutB == GATE_OFF)
        else $error("outputs on during supply fault");
    oc_trip_a: assert property (ocTrip |=> stateReg == ST_TRIP
        ##1 bridgeOutA == GATE_OFF)
        else $error("overcurrent did not shut down");
    oc_filter_a: assert property ($rose(ocTrip) |->
        ocRunReg >= ocLimit)
        else $error("overcurrent tripped before filter time");
    timed_recover_a: assert property (stateReg == ST_TRIP && !tripNow
        && !stopCmd && oscRise && edgeReg == EDGE_LAST && autoOk
        |=> stateReg == ST_RUN)
        else $error("no recovery after stop interval");
    hot_latched_a: assert property (stateReg == ST_TRIP && causeHotReg
        && stage2Reg.oscGnd && !stopCmd |=> stateReg == ST_TRIP)
        else $error("thermal trip recovered by itself");
    oc_latched_a: assert property (stateReg == ST_TRIP && causeOcReg
        && stage2Reg.oscOpn && !stopCmd |=> stateReg == ST_TRIP)
        else $error("overcurrent trip recovered by itself");
    timer_restart_a: assert property (tripNow |=> edgeReg == '0
        && stateReg == ST_TRIP)
        else $error("stop timer not restarted");

    trip_seen_c:    cover property ($rose(stateReg == ST_TRIP));
    auto_recover_c: cover property (stateReg == ST_TRIP && oscRise
        && edgeReg == EDGE_LAST ##1 stateReg == ST_RUN);
    reverse_c:      cover property ($fell(bridgeOutA.hiOn)
        ##[1:40] bridgeOutA.loOn);

endmodule

// ==== core/hbridge_pkg.sv ====
// constants and carrier types for the h-bridge mode and fault logic
// assumes a single 50 MHz clock and pins synchronised inside the core
package hbridge_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLOCK_PERIOD_NS = 20;
    localparam int OC_TIME_FAST_NS = 1600;
    localparam int OC_TIME_MID_NS  = 2800;
    localparam int OC_TIME_SLOW_NS = 12400;
    // least times round up to whole cycles
    localparam int OC_CYC_FAST =
        (OC_TIME_FAST_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int OC_CYC_MID =
        (OC_TIME_MID_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int OC_CYC_SLOW =
        (OC_TIME_SLOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int OC_CNT_W = 10;

    // stop interval in hundredths of an oscillator period
    localparam int STOP_OSC_X100 = 517;
    localparam int STOP_EDGES    = (STOP_OSC_X100 + 99) / 100;
    localparam int EDGE_CNT_W    = 3;

    localparam int DEAD_CYCLES_DEF = 10;
    localparam int NUM_SWITCHES    = 4;

    // ==========================================================
    // detection time select codes
    localparam logic [1:0] OC_SEL_FAST = 2'h0;
    localparam logic [1:0] OC_SEL_MID  = 2'h1;
    localparam logic [1:0] OC_SEL_SLOW = 2'h2;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        HB_OFF  = 3'h1,
        HB_HIGH = 3'h2,
        HB_LOW  = 3'h4
    } hb_drive_t;

    typedef enum logic [1:0] {
        ST_RUN  = 2'h1,
        ST_TRIP = 2'h2
    } guard_state_t;

    typedef struct packed {
        logic hiOn;
        logic loOn;
    } hb_gate_t;

    typedef struct packed {
        logic       undervoltageLockout;
        logic       overvoltageShutdown;
        logic       thermalShutdown;
        logic [3:0] overcurrentShutdown;
    } prot_flags_t;

    typedef struct packed {
        logic dirInA;
        logic dirInB;
        logic pwmIn;
    } drive_cmd_t;

    localparam hb_gate_t GATE_OFF = 2'h0;

endpackage

// ==== testbench/host_drive.sv ====
// host side model: drives the direction and pwm pins of the block
// assumes the bench supplies a steady command and a chop mode
`timescale 1ns/10ps
module host_drive #(
    parameter int PULSE_CYC = 50
) (
    input  wire logic                    clock,    // bench clock
    input  wire logic                    sys_rst,  // sync reset
    input  wire hbridge_pkg::drive_cmd_t cmdIn,    // wanted pin levels
    input  wire logic [1:0]              chopMode, // 0 none 1 pwm 2 dir
    output hbridge_pkg::drive_cmd_t      driveCmd  // pins to the device
);
    import hbridge_pkg::*;

    // ==========================================================
    // chop phase
    int         phaseCnt_reg;
    logic       phase_reg;
    drive_cmd_t driveCmd_next;

    // pulse width kept
    // phase flips every PULSE_CYC cycles, 1 us at 50 MHz
    always_ff @(posedge clock) begin
        if (sys_rst || phaseCnt_reg == PULSE_CYC - 1) begin
            phaseCnt_reg <= 0;
            phase_reg    <= sys_rst ? 1'b1 : !phase_reg;
        end else begin
            phaseCnt_reg <= phaseCnt_reg + 1;
        end
    end

    // pwm pin or dir pins
    // chopping the dir pins alternates drive with stop
    always_comb begin
        driveCmd_next = cmdIn;
        if (chopMode == 2'h1) begin
            driveCmd_next.pwmIn = cmdIn.pwmIn & phase_reg;
        end else if (chopMode == 2'h2) begin
            driveCmd_next.dirInA = cmdIn.dirInA & phase_reg;
            driveCmd_next.dirInB = cmdIn.dirInB & phase_reg;
            driveCmd_next.pwmIn  = 1'b1;
        end
    end

    // pins change only just after an edge
    always_ff @(posedge clock) begin
        driveCmd <= driveCmd_next;
    end
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the h-bridge mode and fault logic
// assumes the host model drives the pins and the bench the flags
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import hbridge_pkg::*;

    // ==========================================================
    // constants and signals
    localparam int         DEAD = 2;
    localparam hb_gate_t   HI   = 2'h2;
    localparam hb_gate_t   LO   = 2'h1;
    localparam logic [4:0] FWD  = 5'h13;  // a high, b low, fault low
    localparam logic [4:0] TRIP = 5'h00;  // all off, fault released
    localparam logic [4:0] IDLE = 5'h01;  // stop, fault low

    typedef struct packed {
        drive_cmd_t cmd;
        logic [4:0] outs;
    } row_t;

    logic        clock       = 1'b0;
    logic        sys_rst     = 1'b1;
    drive_cmd_t  cmd         = 3'h0;
    logic [1:0]  chop        = 2'h0;
    prot_flags_t protFlags   = 7'h00;
    logic        recoveryOsc = 1'b0;
    logic        oscGrounded = 1'b0;
    logic        oscOpen     = 1'b0;
    logic [1:0]  ocSel       = 2'h0;
    drive_cmd_t  driveCmd;
    hb_gate_t    bridgeOutA;
    hb_gate_t    bridgeOutB;
    logic        faultIn;
    logic        faultOut;
    logic        faultOe;
    logic [4:0]  outs;
    int          n_fail       = 0;
    int          total_checks = 0;
    int          cycles       = 0;
    hb_gate_t    lastOn [2]   = '{2'h0, 2'h0};
    int          offCnt [2]   = '{0, 0};
    row_t        rows [9]     = '{
        '{3'h7, 5'h0b}, '{3'h6, 5'h0b}, '{3'h5, FWD}, '{3'h3, 5'h0d},
        '{3'h5, FWD}, '{3'h4, 5'h0b}, '{3'h2, 5'h0b}, '{3'h1, IDLE},
        '{3'h0, IDLE}};

    // open-drain fault pin with an external pull-up
    assign faultIn = faultOe ? faultOut : 1'b1;
    assign outs    = {bridgeOutA, bridgeOutB, faultOe};

    always #10 clock = ~clock;

    host_drive host_drive_inst (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .cmdIn    (cmd),
        .chopMode (chop),
        .driveCmd (driveCmd)
    );

    hbridge_mode_and_fault_control #(
        .DEAD_CYCLES (DEAD)
    ) hbridge_mode_and_fault_control_inst (
        .clock                 (clock),
        .sys_rst               (sys_rst),
        .driveCmd              (driveCmd),
        .protFlags             (protFlags),
        .recoveryOsc           (recoveryOsc),
        .oscGrounded           (oscGrounded),
        .oscOpen               (oscOpen),
        .overcurrentTimeSelect (ocSel),
        .bridgeOutA            (bridgeOutA),
        .bridgeOutB            (bridgeOutB),
        .faultIn               (faultIn),
        .faultOut              (faultOut),
        .faultOe               (faultOe)
    );

    // ==========================================================
    // closing, timeout and helpers
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ceiling well above the roughly 4200 cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            end_sim();
        end
    end

    // sample on the falling edge, where outputs are settled
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic pulse_flags(input prot_flags_t f, input int n);
        @(posedge clock);
        protFlags <= f;
        repeat (n) @(posedge clock);
        protFlags <= 7'h00;
    endtask

    task automatic osc_edges(input int n);
        repeat (n) begin
            @(posedge clock);
            recoveryOsc <= 1'b1;
            repeat (4) @(posedge clock);
            recoveryOsc <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask

    // legs never shoot through
    // a leg swapping hi and lo must stay off for the dead time
    always @(negedge clock) begin
        for (int k = 0; k < 2; k++) begin
            hb_gate_t g;
            g = k ? bridgeOutB : bridgeOutA;
            if (!sys_rst) begin
                `CHK(g.hiOn & g.loOn, 1'b0)
                if (g == GATE_OFF) begin
                    offCnt[k]++;
                end else begin
                    if (g != lastOn[k] && lastOn[k] != GATE_OFF) begin
                        `CHK(offCnt[k] >= DEAD, 1'b1)
                    end
                    lastOn[k] = g;
                    offCnt[k] = 0;
                end
            end
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        int lim;
        int hiCnt;
        int bHi;
        settle(4);
        `CHK(outs, TRIP)
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        settle(6);
        `CHK(outs, IDLE)
        // ordinary modes, fwd to rev directly
        foreach (rows[i]) begin
            @(posedge clock);
            cmd <= rows[i].cmd;
            settle(12);
            `CHK(outs, rows[i].outs)
            `CHK(faultIn, 1'b0)
        end
        @(posedge clock);
        cmd <= 3'h5;
        // pwm on the pwm pin, then on the dir pins
        for (int m = 1; m < 3; m++) begin
            @(posedge clock);
            chop <= m[1:0];
            settle(4);
            hiCnt = 0;
            bHi   = 0;
            repeat (200) begin
                @(negedge clock);
                hiCnt += (bridgeOutA === HI);
                bHi   += (bridgeOutB === HI);
            end
            `CHK(hiCnt >= 80 && hiCnt <= 120, 1'b1)
            `CHK(bHi, 0)
        end
        @(posedge clock);
        chop <= 2'h0;
        // supply flags are not latched
        for (int k = 0; k < 2; k++) begin
            pulse_flags(k ? 7'h20 : 7'h40, 10);
            settle(0);
            `CHK(outs, TRIP)
            settle(12);
            `CHK(outs, FWD)
        end
        // thermal trip, retrip mid count restarts the stop timer
        pulse_flags(7'h10, 10);
        settle(4);
        `CHK(outs, TRIP)
        `CHK(faultIn, 1'b1)
        osc_edges(3);
        pulse_flags(7'h10, 10);
        settle(4);
        osc_edges(5);
        settle(6);
        `CHK(outs, TRIP)
        osc_edges(1);
        settle(12);
        `CHK(outs, FWD)
        // grounded oscillator: only the host can release
        @(posedge clock);
        oscGrounded <= 1'b1;
        pulse_flags(7'h10, 10);
        settle(4);
        osc_edges(8);
        settle(6);
        `CHK(outs, TRIP)
        @(posedge clock);
        cmd <= 3'h1;
        settle(8);
        `CHK(outs, IDLE)
        @(posedge clock);
        cmd         <= 3'h5;
        oscGrounded <= 1'b0;
        settle(12);
        `CHK(outs, FWD)
        // each switch, each time code; odd rounds leave osc open
        for (int i = 0; i < 4; i++) begin
            lim = (i == 0) ? OC_CYC_FAST : (i == 1) ? OC_CYC_MID
                : OC_CYC_SLOW;
            @(posedge clock);
            ocSel   <= i[1:0];
            oscOpen <= i[0];
            pulse_flags(7'h01 << i, lim - 3);
            settle(6);
            `CHK(outs, FWD)
            pulse_flags(7'h01 << i, lim + 4);
            settle(0);
            `CHK(outs, TRIP)
            osc_edges(7);
            settle(12);
            `CHK(outs, i[0] ? TRIP : FWD)
            @(posedge clock);
            cmd <= 3'h1;
            settle(8);
            `CHK(outs, IDLE)
            @(posedge clock);
            cmd <= 3'h5;
            settle(12);
        end
        // reset in mid drive
        @(posedge clock);
        sys_rst <= 1'b1;
        settle(2);
        `CHK(outs, TRIP)
        @(posedge clock);
        sys_rst <= 1'b0;
        settle(12);
        `CHK(outs, FWD)
        end_sim();
    end
endmodule
